// ---- hdl/rsc_reset_ctrl.v ----
/*
 reset and stop-mode recovery sequencer with a wishbone register slave.
 assumes osc_tick_i pulses once per internal oscillator cycle, clock_i
 stands for the free-running system clock, and the pin has an external pull-up.
*/
// What this block does
// [R1] any system reset holds the device for 66 oscillator cycles
// [R2] reset start makes every gpio an input and turns pull-ups off
// [R3] pwm outputs float first, then take the programmed off state
// [R4] option bits load in first 50 oscillator cycles, then clock starts
// [R5] core stays inactive 16 system clocks after the 66-cycle oscillator count ends
// [R6] control registers with defined reset values are loaded on reset
// [R7] after release the cpu fetches the vector at address 0004H
// [R8] power-on or brownout wins over every other reset source
// [R9] stop mode accepts only power-on, brownout, pin and fault resets
// [R10] power-on reset sets the power-on cause flag
// [R11] brownout-in-stop option keeps or gates the brownout detector
// [R12] watchdog time-out resets when the reset select option is one
// [R13] pin low for four system clocks enters reset, held while low
// [R14] pin held past time-out releases 16 clocks after pin release
// [R15] pin released early is driven low until the time-out ends
// [R16] stop mode bypasses the digital filter on the reset pin
// [R17] pin reset sets the external pin cause flag
// [R18] internal reset events drive the pin low until latency ends
// [R19] writing bit 0 resets; debugger writes spare the debugger
// [R20] fault detection forces reset and sets the fault cause flag
// [R21] stop recovery holds 66 cycles, fetches vector, sets stop flag
// [R22] in stop, watchdog or gpio transitions start stop recovery
// [R23] every event rewrites all cause flags to the latest one
`include "rsc_consts.vh"

module rsc_reset_ctrl (
  // clock and power-on reset
  input  wire                     clock_i,
  input  wire                     rst_n_i,
  input  wire                     osc_tick_i,
  // reset sources
  input  wire                     brownout_detector_i,
  input  wire                     watchdog_timeout_i,
  input  wire                     fault_detect_i,
  input  wire                     gpio_wake_i,
  input  wire                     stop_mode_i,
  // open-drain reset pin
  input  wire                     reset_pin_i,
  output wire                     reset_pin_o,
  output wire                     reset_pin_oe_o,
  // wishbone slave
  input  wire                     wb_cyc_i,
  input  wire                     wb_stb_i,
  input  wire                     wb_we_i,
  input  wire [`RSC_ADDR_W-1:0]   wb_adr_i,
  input  wire [3:0]               wb_sel_i,
  input  wire [31:0]              wb_dat_i,
  input  wire                     wb_dbg_i,
  output reg  [31:0]              wb_dat_o,
  output wire                     wb_ack_o,
  // reset outputs to the system
  output reg                      core_reset_o,
  output reg                      debug_reset_o,
  output reg                      sys_clk_en_o,
  output reg                      option_load_o,
  output reg                      gpio_force_input_o,
  output reg                      gpio_pullup_off_o,
  output reg                      pwm_hiz_o,
  output reg                      pwm_force_off_o,
  output reg  [`RSC_PWM_W-1:0]    pwm_off_state_o,
  output reg                      brownout_enable_o,
  output reg                      stop_recovery_o,
  output reg                      wdt_exception_o,
  output reg  [31:0]              reset_vector_o
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam ST_RUN  = 2'h0;
  localparam ST_OSC  = 2'h1;
  localparam ST_SYS  = 2'h2;
  localparam ST_HOLD = 2'h3;

  reg [1:0]                state_r;
  reg [`RSC_CNT_W-1:0]     osc_cnt_r;
  reg [4:0]                sys_cnt_r;
  reg [`RSC_CAUSE_W-1:0]   cause_r;
  reg [`RSC_CAUSE_W-1:0]   pend_r;
  reg                      recov_r;
  reg                      dbg_req_r;
  reg                      wdt_exc_pend_r;
  reg [1:0]                option_r;
  reg [`RSC_PWM_W-1:0]     pwmoff_r;
  reg                      ack_r;

  // ---------------------------------------------------------------
  // reset pin synchroniser and filter
  // ---------------------------------------------------------------
  reg [2:0] pin_sync_r;
  reg       pin_low_r;
  reg [2:0] pin_cnt_r;
  wire      pin_agree = (pin_sync_r[1] == pin_sync_r[2]);
  wire      pin_lvl_low = ~pin_sync_r[2];

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sync_r <= 3'h7;
      pin_low_r  <= 1'b0;
      pin_cnt_r  <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], reset_pin_i};
      // [R16] stop mode filter bypass
      if (stop_mode_i) begin
        if (pin_agree)
          pin_low_r <= pin_lvl_low;
        pin_cnt_r <= 3'h0;
      // [R13] four-clock low filter
      end else if (pin_agree && pin_lvl_low) begin
        if (pin_cnt_r != `RSC_PIN_MIN - 3'h1)
          pin_cnt_r <= pin_cnt_r + 3'h1;
        else
          pin_low_r <= 1'b1;
      end else if (pin_agree) begin
        pin_cnt_r <= 3'h0;
        pin_low_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // source qualification
  // ---------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire sw_wr   = bus_req & ~ack_r & wb_we_i & wb_sel_i[0]
                 & (wb_adr_i == `RSC_OFS_CAUSE) & wb_dat_i[`RSC_BIT_SWRST];
  wire run     = (state_r == ST_RUN);
  // [R9][R12] sources by mode, watchdog select
  wire src_wdt = run & ~stop_mode_i & watchdog_timeout_i
                 & option_r[`RSC_OPT_WATCHDOG_RESET_SELECT];
  wire src_usr = run & ~stop_mode_i & sw_wr;
  wire src_ext = pin_low_r;
  wire src_flt = fault_detect_i;
  // [R11] brownout gating in stop
  wire bo_live = brownout_detector_i
                 & (~stop_mode_i | option_r[`RSC_OPT_BO_STOP]);
  // [R22] stop recovery sources
  wire src_rec = run & stop_mode_i & (watchdog_timeout_i | gpio_wake_i);
  wire any_sys = bo_live | src_wdt | src_usr | src_ext | src_flt;

  // [R8] power-on first, then others
  reg [`RSC_CAUSE_W-1:0] new_cause;
  always @* begin
    new_cause = {`RSC_CAUSE_W{1'b0}};
    if (bo_live)
      new_cause[`RSC_BIT_POR] = 1'b1;
    else if (src_flt)
      new_cause[`RSC_BIT_FLT] = 1'b1;
    else if (src_ext)
      new_cause[`RSC_BIT_EXT] = 1'b1;
    else if (src_wdt)
      new_cause[`RSC_BIT_WDT] = 1'b1;
    else if (src_usr)
      new_cause[`RSC_BIT_USR] = 1'b1;
    else if (src_rec) begin
      new_cause[`RSC_BIT_STOP] = 1'b1;
      new_cause[`RSC_BIT_WDT]  = watchdog_timeout_i;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r        <= ST_OSC;
      osc_cnt_r      <= {`RSC_CNT_W{1'b0}};
      sys_cnt_r      <= 5'h0;
      cause_r        <= {`RSC_CAUSE_W{1'b0}};
      pend_r         <= `RSC_CAUSE_POR_INIT;
      recov_r        <= 1'b0;
      dbg_req_r      <= 1'b0;
      wdt_exc_pend_r <= 1'b0;
      option_r       <= `RSC_OPT_RESET;
      wdt_exception_o <= 1'b0;
    end else begin
      wdt_exception_o <= 1'b0;
      if (bo_live && pend_r[`RSC_BIT_POR] == 1'b0 && !run) begin
        // [R8] brownout restarts the full sequence
        state_r   <= ST_OSC;
        osc_cnt_r <= {`RSC_CNT_W{1'b0}};
        pend_r    <= new_cause;
        recov_r   <= 1'b0;
        dbg_req_r <= 1'b0;
      end else begin
        case (state_r)
          ST_RUN: begin
            if (any_sys || src_rec) begin
              state_r   <= ST_OSC;
              osc_cnt_r <= {`RSC_CNT_W{1'b0}};
              pend_r    <= new_cause;
              recov_r   <= ~any_sys;
              // [R19] debugger write spares debugger
              dbg_req_r <= src_usr & ~(bo_live | src_flt | src_ext | src_wdt) & wb_dbg_i;
              // [R22] exception after recovery
              wdt_exc_pend_r <= ~any_sys & watchdog_timeout_i
                                & ~option_r[`RSC_OPT_WATCHDOG_RESET_SELECT];
            end
          end
          ST_OSC: begin
            if (osc_tick_i)
              osc_cnt_r <= osc_cnt_r + 7'h1;
            // [R1] 66 oscillator cycles; [R21] same for recovery
            if (osc_tick_i && osc_cnt_r == `RSC_OSC_TOTAL - 7'h1) begin
              state_r   <= ST_SYS;
              sys_cnt_r <= 5'h0;
            end
          end
          ST_SYS: begin
            sys_cnt_r <= sys_cnt_r + 5'h1;
            // [R5] 16 system clocks
            if (sys_cnt_r == `RSC_SYS_CYCLES - 5'h1) begin
              if (pin_low_r)
                state_r <= ST_HOLD;
              else begin
                state_r <= ST_RUN;
                // [R23] rewrite all flags; [R10][R17][R20][R21] cause set
                cause_r <= pend_r;
                wdt_exception_o <= wdt_exc_pend_r;
                wdt_exc_pend_r  <= 1'b0;
              end
            end
          end
          default: begin
            // [R14] 16 clocks after pin release
            if (pin_low_r)
              sys_cnt_r <= 5'h0;
            else if (sys_cnt_r == `RSC_SYS_CYCLES - 5'h1) begin
              state_r <= ST_RUN;
              cause_r <= pend_r;
            end else
              sys_cnt_r <= sys_cnt_r + 5'h1;
          end
        endcase
      end
      // [R6] option register loads its defined value at option time
      if (state_r == ST_OSC && !recov_r && osc_cnt_r == 7'h0)
        option_r <= `RSC_OPT_RESET;
      else if (run && bus_req && !ack_r && wb_we_i && wb_sel_i[0]
               && wb_adr_i == `RSC_OFS_OPTION)
        option_r <= wb_dat_i[1:0];
    end
  end

  // ---------------------------------------------------------------
  // reset outputs
  // ---------------------------------------------------------------
  wire in_osc    = (state_r == ST_OSC);
  wire sys_reset = ~run & ~recov_r;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_reset_o       <= 1'b1;
      debug_reset_o      <= 1'b1;
      sys_clk_en_o       <= 1'b0;
      option_load_o      <= 1'b0;
      gpio_force_input_o <= 1'b1;
      gpio_pullup_off_o  <= 1'b1;
      pwm_hiz_o          <= 1'b1;
      pwm_force_off_o    <= 1'b0;
      pwm_off_state_o    <= {`RSC_PWM_W{1'b0}};
      pwmoff_r           <= {`RSC_PWM_W{1'b0}};
      brownout_enable_o  <= 1'b1;
      stop_recovery_o    <= 1'b0;
      reset_vector_o     <= `RSC_RESET_VECTOR;
    end else begin
      core_reset_o      <= ~run;
      debug_reset_o     <= sys_reset & ~dbg_req_r;
      // [R4] clock after 50 oscillator cycles
      sys_clk_en_o      <= ~(in_osc && osc_cnt_r < `RSC_OSC_OPTION);
      option_load_o     <= in_osc & ~recov_r & (osc_cnt_r < `RSC_OSC_OPTION);
      // [R2] gpio inputs, pull-ups off
      gpio_force_input_o <= sys_reset;
      gpio_pullup_off_o  <= sys_reset;
      // [R3] float until options evaluated, then off state
      pwm_hiz_o         <= sys_reset & in_osc & (osc_cnt_r < `RSC_OSC_OPTION);
      pwm_force_off_o   <= sys_reset & ~(in_osc & (osc_cnt_r < `RSC_OSC_OPTION));
      pwm_off_state_o   <= pwmoff_r;
      if (run && bus_req && !ack_r && wb_we_i && wb_sel_i[0]
          && wb_adr_i == `RSC_OFS_PWMOFF)
        pwmoff_r <= wb_dat_i[`RSC_PWM_W-1:0];
      // [R11] detector enable
      brownout_enable_o <= ~stop_mode_i | option_r[`RSC_OPT_BO_STOP];
      stop_recovery_o   <= ~run & recov_r;
      // [R7] vector address
      reset_vector_o    <= `RSC_RESET_VECTOR;
    end
  end

  // ---------------------------------------------------------------
  // open-drain pin drive
  // ---------------------------------------------------------------
  // [R15][R18] drive low through the oscillator time-out
  // released before the system-clock tail so own drive is not seen as a hold
  reg pin_drive_r;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      pin_drive_r <= 1'b1;
    else
      pin_drive_r <= (state_r == ST_OSC) & ~recov_r;
  end
  assign reset_pin_o    = 1'b0;
  assign reset_pin_oe_o = pin_drive_r;

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req && !ack_r && !wb_we_i) begin
        case (wb_adr_i)
          `RSC_OFS_CAUSE:  wb_dat_o <= {24'h000000, cause_r[7:2], 2'h0};
          `RSC_OFS_OPTION: wb_dat_o <= {30'h00000000, option_r};
          `RSC_OFS_STATE:  wb_dat_o <= {29'h00000000, recov_r, state_r};
          `RSC_OFS_PWMOFF: wb_dat_o <= {24'h000000, pwmoff_r};
          default:         wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_r;

endmodule

// ---- hdl/rsc_consts.vh ----
/*
 reset controller constants: register offsets, cause bit positions, counts.
 assumes a 50 MHz system clock and a Wishbone slave with 32-bit data.
*/
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define RSC_ADDR_W          4
`define RSC_OFS_CAUSE       4'h0
`define RSC_OFS_OPTION      4'h4
`define RSC_OFS_STATE       4'h8
`define RSC_OFS_PWMOFF      4'hC

// ---------------------------------------------------------------
// cause register bits
// ---------------------------------------------------------------
`define RSC_BIT_SWRST       0
`define RSC_BIT_FLT         2
`define RSC_BIT_EXT         3
`define RSC_BIT_USR         4
`define RSC_BIT_WDT         5
`define RSC_BIT_STOP        6
`define RSC_BIT_POR         7
`define RSC_CAUSE_W         8
`define RSC_CAUSE_POR_INIT  8'h80

// ---------------------------------------------------------------
// option register bits and reset value
// ---------------------------------------------------------------
`define RSC_OPT_WATCHDOG_RESET_SELECT     0
`define RSC_OPT_BO_STOP     1
`define RSC_OPT_RESET       2'h1

// ---------------------------------------------------------------
// sequence counts
// ---------------------------------------------------------------
`define RSC_OSC_TOTAL       7'h42
`define RSC_OSC_OPTION      7'h32
`define RSC_SYS_CYCLES      5'h10
`define RSC_PIN_MIN         3'h4
`define RSC_CNT_W           7
`define RSC_RESET_VECTOR    32'h00000004
`define RSC_PWM_W           8

`endif

// ---- tb/rsc_reset_ctrl_assertions.sv ----
/* port checker for rsc_reset_ctrl.
   assumes it is bound to the top module and sees only its ports. */
module rsc_reset_ctrl_assertions (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        osc_tick_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // sequencer outputs
  input wire logic        core_reset_o,
  input wire logic        sys_clk_en_o,
  input wire logic        option_load_o,
  input wire logic        gpio_force_input_o,
  input wire logic        gpio_pullup_off_o,
  input wire logic        pwm_hiz_o,
  input wire logic        pwm_force_off_o,
  input wire logic        stop_recovery_o,
  input wire logic        reset_pin_o,
  input wire logic [31:0] reset_vector_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tick_r;
  // oscillator ticks from the edge at which the core enters reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) tick_r <= 8'h00;
    else if (!core_reset_o) tick_r <= {7'h00, osc_tick_i};
    else if (osc_tick_i && tick_r != 8'hFF) tick_r <= tick_r + 8'h01;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_osc_hold; $fell(core_reset_o) |-> tick_r >= 8'h42; endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("reset too short");
  property p_clk_late; $rose(sys_clk_en_o) |-> tick_r >= 8'h32; endproperty
  a_clk_late: assert property (p_clk_late) else $error("clock started early");
  property p_load_first; option_load_o |-> !sys_clk_en_o; endproperty
  a_load_first: assert property (p_load_first) else $error("load with clock");
  property p_core_tail;
    $fell(core_reset_o) && !$past(stop_recovery_o, 1) && !$past(stop_recovery_o, 2)
      |-> $past(sys_clk_en_o, 16);
  endproperty
  a_core_tail: assert property (p_core_tail) else $error("core tail short");
  property p_gpio_safe;
    $fell(core_reset_o) && !$past(stop_recovery_o, 1) && !$past(stop_recovery_o, 2)
      |-> $past(gpio_force_input_o && gpio_pullup_off_o, 4);
  endproperty
  a_gpio_safe: assert property (p_gpio_safe) else $error("gpio not safe");
  property p_pwm_order; $rose(pwm_force_off_o) |-> $past(pwm_hiz_o); endproperty
  a_pwm_order: assert property (p_pwm_order) else $error("pwm order");
  property p_vector; reset_vector_o == 32'h00000004; endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");
  property p_pin_od; reset_pin_o == 1'b0; endproperty
  a_pin_od: assert property (p_pin_od) else $error("pin driven high");
  c_release: cover property ($fell(core_reset_o));
  c_stop: cover property ($rose(stop_recovery_o));
  c_clk: cover property ($rose(sys_clk_en_o));
endmodule

// ---- tb/rsc_pin_partner.sv ----
/* board side of the reset line: pull-up plus an agent pulling low.
   assumes the device drives only low, through its enable. */
module rsc_pin_partner (
  // device side
  input  wire logic clock_i,
  input  wire logic dev_oe_i,
  // bench command
  input  wire logic hold_i,
  // resolved line
  output wire logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ext_low_r = 1'b0;
  always_ff @(posedge clock_i) ext_low_r <= hold_i;
  assign pin_o = !(dev_oe_i || ext_low_r);
endmodule

// ---- tb/rsc_reset_ctrl_tb_top.sv ----
/* self-checking bench for rsc_reset_ctrl.
   assumes the pin partner model and the bound port checker. */
`include "rsc_consts.vh"
module rsc_reset_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i, rst_n_i, osc_tick_i, stop_mode_i, hold_r;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_dbg_i;
  logic [3:0]  wb_adr_i, wb_sel_i, src_r;
  logic [31:0] wb_dat_i, exp_q[$];
  wire         reset_pin_i, reset_pin_o, reset_pin_oe_o, wb_ack_o, core_reset_o;
  wire         debug_reset_o, sys_clk_en_o, option_load_o, gpio_force_input_o;
  wire         gpio_pullup_off_o, pwm_hiz_o, pwm_force_off_o, brownout_enable_o;
  wire         stop_recovery_o, wdt_exception_o;
  wire [31:0]  wb_dat_o, reset_vector_o;
  wire [7:0]   pwm_off_state_o;
  int          n_errors, total_checks, cyc_n, k, n_exc;
  int          seed = 32'h6B3D;
  logic [31:0] d;
  rsc_reset_ctrl dut_u (.clock_i, .rst_n_i, .osc_tick_i, .brownout_detector_i(src_r[0]),
    .watchdog_timeout_i(src_r[1]), .fault_detect_i(src_r[2]), .gpio_wake_i(src_r[3]),
    .stop_mode_i, .reset_pin_i, .reset_pin_o, .reset_pin_oe_o, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dbg_i, .wb_dat_o, .wb_ack_o,
    .core_reset_o, .debug_reset_o, .sys_clk_en_o, .option_load_o, .gpio_force_input_o,
    .gpio_pullup_off_o, .pwm_hiz_o, .pwm_force_off_o, .pwm_off_state_o,
    .brownout_enable_o, .stop_recovery_o, .wdt_exception_o, .reset_vector_o);
  rsc_pin_partner pin_u (.clock_i, .dev_oe_i(reset_pin_oe_o), .hold_i(hold_r),
    .pin_o(reset_pin_i));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) osc_tick_i <= !osc_tick_i;
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  always @(posedge clock_i) begin
    cyc_n++;
    if (wdt_exception_o === 1'b1) n_exc++;
    if (cyc_n == 20000) begin
      n_errors++;
      complete_run;
    end
    if (wb_ack_o === 1'b1 && !wb_we_i) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected read");
      else chk(wb_dat_o === exp_q.pop_front(), "read data");
    end
  end
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= v;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clock_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk(n < 20, "no ack");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // wait out one reset, then read the cause flags
  task automatic ev(input logic [7:0] c, input logic dbg, output int n);
    n = 0;
    while (core_reset_o !== 1'b1 && n < 40) begin
      @(posedge clock_i);
      n++;
    end
    n = 0;
    while (core_reset_o !== 1'b0 && n < 2000) begin
      @(posedge clock_i);
      n++;
      if (dbg && debug_reset_o !== 1'b0) chk(1'b0, "debugger reset");
    end
    chk(n < 2000, "reset never ended");
    repeat (2) @(posedge clock_i);
    rd(`RSC_OFS_CAUSE, {24'h0, c});
  endtask
  task automatic quiet(input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge clock_i);
      ok &= (core_reset_o === 1'b0);
    end
    chk(ok, "unexpected reset");
  endtask
  task automatic kick(input logic [3:0] m);
    src_r <= m;
    repeat (2) @(posedge clock_i);
    src_r <= 4'h0;
  endtask
  initial begin
    {n_errors, total_checks, cyc_n, n_exc} = 0;
    {rst_n_i, osc_tick_i, stop_mode_i, hold_r, src_r} = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_dbg_i, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    ev(8'h80, 1'b0, k);
    rd(`RSC_OFS_OPTION, 32'h1);
    rd(`RSC_OFS_STATE, 32'h0);
    rd(4'h2, 32'h0);
    d = $random(seed);
    bus(1'b1, `RSC_OFS_PWMOFF, d);
    rd(`RSC_OFS_PWMOFF, {24'h0, d[7:0]});
    chk(pwm_off_state_o === d[7:0], "pwm off state");
    bus(1'b1, `RSC_OFS_CAUSE, 32'h0);
    quiet(30);
    bus(1'b1, `RSC_OFS_CAUSE, 32'h1);
    ev(8'h10, 1'b0, k);
    wb_dbg_i <= 1'b1;
    bus(1'b1, `RSC_OFS_CAUSE, 32'h1);
    wb_dbg_i <= 1'b0;
    ev(8'h10, 1'b1, k);
    kick(4'h2);
    repeat (6) @(posedge clock_i);
    chk(reset_pin_i === 1'b0, "pin not driven");
    ev(8'h20, 1'b0, k);
    bus(1'b1, `RSC_OFS_OPTION, 32'h0);
    kick(4'h2);
    quiet(40);
    kick(4'h4);
    ev(8'h04, 1'b0, k);
    kick(4'h7);
    ev(8'h80, 1'b0, k);
    hold_r <= 1'b1;
    repeat (3) @(posedge clock_i);
    hold_r <= 1'b0;
    quiet(30);
    hold_r <= 1'b1;
    repeat (20) @(posedge clock_i);
    hold_r <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(reset_pin_i === 1'b0, "pin released early");
    ev(8'h08, 1'b0, k);
    hold_r <= 1'b1;
    repeat (400) @(posedge clock_i);
    chk(core_reset_o === 1'b1, "left reset while held");
    hold_r <= 1'b0;
    ev(8'h08, 1'b0, k);
    chk(k >= 17 && k <= 32, "release delay");
    stop_mode_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk(brownout_enable_o === 1'b0, "brownout kept in stop");
    bus(1'b1, `RSC_OFS_CAUSE, 32'h1);
    quiet(30);
    kick(4'h8);
    ev(8'h40, 1'b0, k);
    rd(`RSC_OFS_STATE, 32'h4);
    hold_r <= 1'b1;
    repeat (3) @(posedge clock_i);
    hold_r <= 1'b0;
    ev(8'h08, 1'b0, k);
    stop_mode_i <= 1'b0;
    bus(1'b1, `RSC_OFS_OPTION, 32'h2);
    stop_mode_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk(brownout_enable_o === 1'b1, "brownout off in stop");
    kick(4'h2);
    ev(8'h60, 1'b0, k);
    chk(n_exc == 1, "no watchdog exception");
    stop_mode_i <= 1'b0;
    complete_run;
  end
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_assertions chk_u (.clock_i, .rst_n_i, .osc_tick_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .core_reset_o, .sys_clk_en_o, .option_load_o,
  .gpio_force_input_o, .gpio_pullup_off_o, .pwm_hiz_o, .pwm_force_off_o,
  .stop_recovery_o, .reset_pin_o, .reset_vector_o);
